// >>> asrc_pkg.sv
// constants, carrier structs and state types of the rate converter control
// assumes a single 40 MHz system clock and synchronous pin inputs
package asrc_pkg;

   // ***********************************************************
   // clock and timing
   // ***********************************************************
   localparam int CLK_HZ = 40_000_000;
   // loop settling targets: slow 800 ms, fast 200 ms at ~48 kHz frames
   localparam int SLOW_SETTLE_MS = 800;
   localparam int FAST_SETTLE_MS = 200;
   // 2**shift frames approximates the settling time in frames
   localparam int SLOW_SHIFT = 15;
   localparam int FAST_SHIFT = 13;
   localparam int PER_FRAC = 16;
   localparam logic [15:0] PER_MAX = 16'hFFFF;
   localparam logic [15:0] PER_MIN = 16'h0001;

   // ***********************************************************
   // sample storage
   // ***********************************************************
   localparam int SAMPLE_W = 16;
   localparam int FIFO_DEPTH = 4;
   localparam int RING_DEPTH = 8;
   localparam logic [3:0] RING_FULL = 4'h8;
   localparam logic [3:0] PTR_SPACING = 4'h5;
   localparam logic [1:0] MUTE_HOLD = 2'h2;
   localparam logic MUTE_RESET = 1'b1;

   // ***********************************************************
   // cutoff and taps
   // ***********************************************************
   localparam longint CUT_REF_HZ = 20_000;
   localparam longint RATE_REF_HZ_X10 = 441_000;
   localparam logic [31:0] CUT_NUM =
      32'(longint'(CLK_HZ) * CUT_REF_HZ * 10 / RATE_REF_HZ_X10);
   localparam int CUT_SHIFT = 4;
   localparam logic [15:0] CUT_GRID_HZ = 16'h012C;
   localparam logic [15:0] CUT_HYST_HZ = 16'h012C;
   localparam logic [7:0] TAPS_UP = 8'h40;
   localparam logic [7:0] TAPS_MAX = 8'h80;
   localparam logic [17:0] RATIO_ONE = 18'h1_0000;
   localparam logic [5:0] DIV_STEPS = 6'h20;

   // ***********************************************************
   // carriers
   // ***********************************************************
   typedef struct packed {
      logic [SAMPLE_W-1:0] left;
      logic [SAMPLE_W-1:0] right;
   } asrc_sample_t;

   typedef struct packed {
      logic [15:0] base;
      logic [16:0] step;
      logic [7:0] taps;
      logic [15:0] cutoff;
      logic [7:0] delay;
   } asrc_coef_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_STEP,
      ST_DPH,
      ST_DRAT,
      ST_DCUT
   } asrc_st_e;

   typedef struct packed {
      logic [2:0] sin;
      logic [2:0] sout;
      logic [15:0] cnt_in;
      logic [15:0] cnt_out;
      logic [31:0] acc_in;
      logic [31:0] acc_out;
      logic seed_in;
      logic seed_out;
      logic [RING_DEPTH-1:0][2*SAMPLE_W-1:0] ring;
      logic [2:0] wr;
      logic [2:0] rd;
      logic [3:0] fill;
      logic priming;
      logic [1:0] hold;
      logic [16:0] phase;
      logic [15:0] base_nx;
      asrc_st_e st;
      logic [31:0] dnum;
      logic [15:0] dden;
      logic [16:0] drem;
      logic [31:0] dquo;
      logic [5:0] dcnt;
      logic [17:0] ratio;
      logic [19:0] cut_sm;
      logic [15:0] cut_sel;
      logic pop;
      asrc_sample_t sample;
      logic valid;
      logic mute;
      asrc_coef_t coef;
   } asrc_core_st_t;

endpackage : asrc_pkg

// >>> asrc_fifo.sv
// small valid/ready FIFO carrying input sample words
// assumes one clock; ready comes from a flip-flop, valid is decoded from the count register
`timescale 1ns/1ps
`default_nettype none
module asrc_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // fill side
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // drain side
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic rdy;
   } asrc_fifo_st_t;

   asrc_fifo_st_t s_q, s_d;
   logic push, pull;

   assign push = in_valid && s_q.rdy;
   assign pull = out_ready && (s_q.cnt != '0);

   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wp] = in_data;
         s_d.wp = AW'((s_q.wp + 1'b1) % DEPTH);
      end
      if (pull)
         s_d.rp = AW'((s_q.rp + 1'b1) % DEPTH);
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pull);
      // ready is registered so the source sees an honest full one cycle on
      s_d.rdy = (s_d.cnt != (AW+1)'(DEPTH));
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign in_ready = s_q.rdy;
   assign out_data = s_q.mem[s_q.rp];
   assign out_valid = (s_q.cnt != '0);

endmodule : asrc_fifo
`default_nettype wire

// >>> asrc_ctrl.sv
// rate converter control: clock ratio servo, sample ring, mute,
// coefficient address scaling, cutoff and tap selection
// assumes lr clocks and samples synchronous to sys_clk at 40 MHz
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // channel clocks and mode
   input wire logic input_channel_clock,
   input wire logic output_channel_clock,
   input wire logic settle_speed_select,
   // input samples
   input wire asrc_pkg::asrc_sample_t in_sample,
   input wire logic in_valid,
   output logic in_ready,
   // output samples
   output asrc_pkg::asrc_sample_t out_sample,
   output logic out_valid,
   output logic mute,
   // filter selection
   output asrc_pkg::asrc_coef_t coef
);
   import asrc_pkg::*;

   asrc_core_st_t s_q, s_d;
   logic [2*SAMPLE_W-1:0] f_data;
   logic f_valid;
   logic f_ready;

   // ***********************************************************
   // helpers
   // ***********************************************************
   function automatic asrc_core_st_t div_start(
      input asrc_core_st_t st,
      input logic [31:0] num,
      input logic [15:0] den
   );
      asrc_core_st_t r;
      r = st;
      r.dnum = num;
      r.dden = (den == '0) ? PER_MIN : den;
      r.drem = '0;
      r.dquo = '0;
      r.dcnt = DIV_STEPS;
      return r;
   endfunction : div_start

   // first-order low-pass of a period, PER_FRAC fraction bits
   function automatic logic [31:0] lp_step(
      input logic [31:0] acc,
      input logic [15:0] meas,
      input logic fast
   );
      logic [31:0] tgt;
      logic [31:0] dif;
      tgt = {meas, 16'h0000};
      if (tgt >= acc)
      begin
         dif = tgt - acc;
         dif = fast ? (dif >> FAST_SHIFT) : (dif >> SLOW_SHIFT);
         return acc + dif;
      end
      dif = acc - tgt;
      dif = fast ? (dif >> FAST_SHIFT) : (dif >> SLOW_SHIFT);
      return acc - dif;
   endfunction : lp_step

   function automatic logic [15:0] sat16(input logic [31:0] v);
      return (v > 32'(PER_MAX)) ? PER_MAX : v[15:0];
   endfunction : sat16

   // ***********************************************************
   // input FIFO
   // ***********************************************************
   asrc_fifo #(
      .W(2 * SAMPLE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .in_data(in_sample),
      .in_valid(in_valid),
      .in_ready(f_ready),
      .out_data(f_data),
      .out_valid(f_valid),
      .out_ready(s_q.pop)
   );

   // ***********************************************************
   // control
   // ***********************************************************
   always_comb
   begin
      logic in_edge;
      logic out_edge;
      logic wr_en;
      logic rd_en;
      logic over;
      logic under;
      logic [16:0] r_try;
      logic [15:0] per_in;
      logic [15:0] per_out;
      logic [19:0] tgt;
      logic [15:0] sm;
      logic [35:0] prod;
      logic [7:0] taps;
      in_edge = 1'b0;
      out_edge = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      over = 1'b0;
      under = 1'b0;
      r_try = '0;
      tgt = '0;
      sm = '0;
      prod = '0;
      taps = TAPS_UP;
      s_d = s_q;
      s_d.valid = 1'b0;
      s_d.pop = 1'b0;
      per_in = s_q.acc_in[31:16];
      per_out = s_q.acc_out[31:16];

      // two-flop synchronisers, third stage is the edge history
      s_d.sin = {s_q.sin[1:0], input_channel_clock};
      s_d.sout = {s_q.sout[1:0], output_channel_clock};
      in_edge = s_q.sin[1] && !s_q.sin[2];
      out_edge = s_q.sout[1] && !s_q.sout[2];

      // period counters saturate so a stopped clock cannot wrap
      s_d.cnt_in = (s_q.cnt_in == PER_MAX) ? PER_MAX : s_q.cnt_in + 1'b1;
      s_d.cnt_out = (s_q.cnt_out == PER_MAX) ? PER_MAX : s_q.cnt_out + 1'b1;

      // both clocks feed the same averaging, so both jitters are rejected
      if (in_edge)
      begin
         s_d.cnt_in = 16'h0001;
         s_d.pop = 1'b1;
         if (!s_q.seed_in)
         begin
            // the first edge after reset only starts a full period count
            s_d.seed_in = (s_q.cnt_in != PER_MAX);
            s_d.acc_in = {s_q.cnt_in, 16'h0000};
         end
         else
            s_d.acc_in = lp_step(s_q.acc_in, s_q.cnt_in,
                                 settle_speed_select);
      end
      if (out_edge)
      begin
         s_d.cnt_out = 16'h0001;
         if (!s_q.seed_out)
         begin
            s_d.seed_out = (s_q.cnt_out != PER_MAX);
            s_d.acc_out = {s_q.cnt_out, 16'h0000};
         end
         else
            s_d.acc_out = lp_step(s_q.acc_out, s_q.cnt_out,
                                  settle_speed_select);
      end

      // ring write, one frame per input channel clock period
      if (s_q.pop)
      begin
         wr_en = 1'b1;
         s_d.ring[s_q.wr] = f_valid ? f_data : '0;
         s_d.wr = s_q.wr + 1'b1;
         over = (s_q.fill == RING_FULL);
      end

      // divider step, restoring, one quotient bit per cycle
      if (s_q.dcnt != '0)
      begin
         r_try = {s_q.drem[15:0], s_q.dnum[31]};
         s_d.dnum = {s_q.dnum[30:0], 1'b0};
         s_d.dcnt = s_q.dcnt - 1'b1;
         if (r_try >= {1'b0, s_q.dden})
         begin
            s_d.drem = r_try - {1'b0, s_q.dden};
            s_d.dquo = {s_q.dquo[30:0], 1'b1};
         end
         else
         begin
            s_d.drem = r_try;
            s_d.dquo = {s_q.dquo[30:0], 1'b0};
         end
      end

      unique case (s_q.st)
         ST_IDLE:
         begin
            if (out_edge && s_q.seed_in && s_q.seed_out)
            begin
               s_d.phase = s_q.phase + {1'b0, per_out};
               s_d.st = ST_STEP;
            end
         end
         ST_STEP:
         begin
            // each whole input period in the phase moves the read pointer, except while priming or with an empty ring
            if (s_q.phase >= {1'b0, per_in})
            begin
               s_d.phase = s_q.phase - {1'b0, per_in};
               if (!s_q.priming)
               begin
                  if (s_q.fill == 4'h0)
                     under = 1'b1;
                  else
                     rd_en = 1'b1;
               end
            end
            else
            begin
               s_d = div_start(s_d, {s_q.phase[15:0], 16'h0000}, per_in);
               s_d.st = ST_DPH;
            end
         end
         ST_DPH:
         begin
            if (s_q.dcnt == '0)
            begin
               // fractional phase picks the polyphase start address
               s_d.base_nx = s_q.dquo[15:0];
               s_d = div_start(s_d, {per_in, 16'h0000}, per_out);
               s_d.st = ST_DRAT;
            end
         end
         ST_DRAT:
         begin
            if (s_q.dcnt == '0)
            begin
               s_d.ratio = (s_q.dquo > 32'(RATIO_ONE)) ? RATIO_ONE
                                                       : s_q.dquo[17:0];
               // cutoff follows the slower rate, i.e. the longer period
               s_d = div_start(s_d, CUT_NUM,
                               (per_out > per_in) ? per_out
                                                  : per_in);
               s_d.st = ST_DCUT;
            end
         end
         ST_DCUT:
         begin
            if (s_q.dcnt == '0)
            begin
               tgt = {sat16(s_q.dquo), 4'h0};
               if (tgt >= s_q.cut_sm)
                  s_d.cut_sm = s_q.cut_sm
                             + ((tgt - s_q.cut_sm) >> CUT_SHIFT);
               else
                  s_d.cut_sm = s_q.cut_sm
                             - ((s_q.cut_sm - tgt) >> CUT_SHIFT);
               sm = s_d.cut_sm[19:4];
               // moves one grid step only past the noise margin
               if (sm > s_q.cut_sel + CUT_HYST_HZ)
                  s_d.cut_sel = s_q.cut_sel + CUT_GRID_HZ;
               else if (sm + CUT_HYST_HZ < s_q.cut_sel)
                  s_d.cut_sel = s_q.cut_sel - CUT_GRID_HZ;
               s_d.coef.cutoff = s_d.cut_sel;
               // base is held back so the whole selection moves with the frame
               s_d.coef.base = s_q.base_nx;

               if (s_q.ratio < RATIO_ONE)
               begin
                  s_d.coef.step = s_q.ratio[16:0];
                  prod = 36'(RATIO_ONE - s_q.ratio) * 36'(TAPS_MAX);
                  taps = TAPS_UP + 8'(prod[35:16]);
                  if (taps > TAPS_MAX)
                     taps = TAPS_MAX;
               end
               else
               begin
                  s_d.coef.step = RATIO_ONE[16:0];
                  taps = TAPS_UP;
               end
               // even tap count keeps the symmetric impulse response
               s_d.coef.taps = {taps[7:1], 1'b0};
               s_d.coef.delay = {4'h0, PTR_SPACING}
                              + {1'b0, taps[7:1]};

               // emit; a muted frame carries silence
               s_d.valid = 1'b1;
               s_d.sample = s_q.ring[s_q.rd];
               if (!s_q.priming && s_q.mute)
               begin
                  if (s_q.hold == '0)
                     s_d.mute = 1'b0;
                  else
                     s_d.hold = s_q.hold - 1'b1;
               end
               s_d.st = ST_IDLE;
            end
         end
      endcase

      // pointer bookkeeping; a crossing re-primes the spacing
      if (rd_en)
         s_d.rd = s_q.rd + 1'b1;
      s_d.fill = s_q.fill + {3'h0, wr_en} - {3'h0, rd_en};
      if (over)
      begin
         // drop the oldest frames so the reader sits five behind again
         s_d.rd = s_d.wr - PTR_SPACING[2:0];
         s_d.fill = PTR_SPACING;
         s_d.mute = 1'b1;
         s_d.hold = MUTE_HOLD;
      end
      if (under)
      begin
         s_d.priming = 1'b1;
         s_d.mute = 1'b1;
         s_d.hold = MUTE_HOLD;
      end
      // silence follows the final mute, so a crossing in the emit cycle counts
      if (s_d.valid && s_d.mute)
         s_d.sample = '0;
      // reading starts only once five frames stand between the pointers
      if (s_q.priming && s_q.fill >= PTR_SPACING)
         s_d.priming = 1'b0;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.mute <= MUTE_RESET;
         s_q.priming <= 1'b1;
         s_q.hold <= MUTE_HOLD;
         s_q.ratio <= RATIO_ONE;
         s_q.cnt_in <= PER_MAX;
         s_q.cnt_out <= PER_MAX;
         s_q.coef.step <= RATIO_ONE[16:0];
         s_q.coef.taps <= TAPS_UP;
      end
      else
         s_q <= s_d;
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   assign in_ready = f_ready;
   assign out_sample = s_q.sample;
   assign out_valid = s_q.valid;
   assign mute = s_q.mute;
   assign coef = s_q.coef;

endmodule : asrc_ctrl
`default_nettype wire

// >>> asrc_ctrl_assertions.sv
// concurrent checks on the rate converter control outputs
// assumes it is bound to asrc_ctrl; one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl_checker (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // observed outputs
   input wire asrc_pkg::asrc_sample_t out_sample,
   input wire logic out_valid,
   input wire logic mute,
   input wire asrc_pkg::asrc_coef_t coef
);
   import asrc_pkg::*;
   logic [15:0] cut_q;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   // last emitted cutoff, so a single frame can move it one grid step only
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         cut_q <= 16'h0000;
      else if (out_valid)
         cut_q <= coef.cutoff;
   end

   // ********
   // properties
   // ********
   property p_mute_zero;
      out_valid && mute |-> out_sample == '0;
   endproperty
   a_mute_zero: assert property (p_mute_zero)
      else $error("muted frame carries data");
   property p_taps;
      out_valid |-> coef.taps >= TAPS_UP && coef.taps <= TAPS_MAX && !coef.taps[0];
   endproperty
   a_taps: assert property (p_taps)
      else $error("tap count out of range");
   property p_delay;
      out_valid |-> coef.delay == 8'(PTR_SPACING) + (coef.taps >> 1);
   endproperty
   a_delay: assert property (p_delay)
      else $error("group delay not spacing plus half taps");
   property p_grid;
      out_valid |-> coef.cutoff % CUT_GRID_HZ == 16'h0000;
   endproperty
   a_grid: assert property (p_grid)
      else $error("cutoff off grid");
   property p_cut_step;
      out_valid |-> (coef.cutoff >= cut_q ? coef.cutoff - cut_q
                     : cut_q - coef.cutoff) <= CUT_HYST_HZ;
   endproperty
   a_cut_step: assert property (p_cut_step)
      else $error("cutoff jumped more than one step");
   property p_pulse;
      out_valid |=> !out_valid [*8];
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("output requests too close");
   property p_stand;
      !out_valid |-> $stable(coef) && $stable(out_sample);
   endproperty
   a_stand: assert property (p_stand)
      else $error("selection changed between frames");
   property p_mute_clr;
      $fell(mute) |-> out_valid;
   endproperty
   a_mute_clr: assert property (p_mute_clr)
      else $error("mute released outside a frame");

   c_unmuted: cover property (out_valid && !mute);
   c_down: cover property (out_valid && coef.taps > TAPS_UP);
   c_mute: cover property ($rose(mute));
endmodule : asrc_ctrl_checker

bind asrc_ctrl asrc_ctrl_checker u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
   .out_sample(out_sample), .out_valid(out_valid), .mute(mute), .coef(coef));
`default_nettype wire

// >>> asrc_audio_partner.sv
// far side model: audio source pacing, lr clocks and sample words
// assumes sys_clk is the only clock; lr clocks are derived from it
`timescale 1ns/1ps
`default_nettype none
module asrc_audio_partner (
   // clock and pacing
   input wire logic sys_clk,
   input wire logic [15:0] in_per,
   input wire logic [15:0] out_per,
   input wire logic in_run,
   input wire logic out_run,
   input wire logic src_en,
   // device side
   output logic input_channel_clock,
   output logic output_channel_clock,
   output asrc_pkg::asrc_sample_t in_sample,
   output logic in_valid,
   input wire logic in_ready
);
   import asrc_pkg::*;
   logic [15:0] icnt = 16'h0000;
   logic [15:0] ocnt = 16'h0000;
   logic [15:0] word = 16'h0000;
   logic took = 1'b0;

   initial
   begin
      input_channel_clock = 1'b0;
      output_channel_clock = 1'b0;
      in_sample = '0;
      in_valid = 1'b0;
   end

   always @(posedge sys_clk)
      took <= in_valid && in_ready;

   // lr clocks run square while enabled and stand low when stopped
   always @(negedge sys_clk)
   begin
      icnt <= (!in_run || icnt + 16'h1 >= in_per) ? 16'h0 : icnt + 16'h1;
      ocnt <= (!out_run || ocnt + 16'h1 >= out_per) ? 16'h0 : ocnt + 16'h1;
      input_channel_clock <= in_run && icnt >= in_per >> 1;
      output_channel_clock <= out_run && ocnt >= out_per >> 1;
      // a word holds until taken; released lines toggle so stale data shows
      if (took || !in_valid)
      begin
         in_valid <= src_en;
         word <= word + 16'(src_en);
         in_sample <= src_en ? {word + 16'h1, 16'($urandom)} : ~in_sample;
      end
   end
endmodule : asrc_audio_partner
`default_nettype wire

// >>> asrc_ctrl_tb.sv
// self-checking bench for the rate converter control
// assumes the partner model paces lr clocks and source words
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl_tb;
   import asrc_pkg::*;
   localparam int LIMIT = 95000;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic settle_speed_select = 1'b0;
   logic in_run = 1'b0;
   logic out_run = 1'b0;
   logic src_en = 1'b0;
   logic [15:0] in_per = 16'h0258;
   logic [15:0] out_per = 16'h0384;
   logic input_channel_clock;
   logic output_channel_clock;
   logic in_valid;
   logic in_ready;
   logic out_valid;
   logic mute;
   asrc_sample_t in_sample;
   asrc_sample_t out_sample;
   asrc_coef_t coef;
   int errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int acc_q[$];
   int ring_last = 0;
   int d, tgt, et, es;
   logic lr_q = 1'b0;
   logic chk_en = 1'b0;
   logic up = 1'b0;

   asrc_ctrl uut (.sys_clk(sys_clk), .arst_n(arst_n),
      .input_channel_clock(input_channel_clock),
      .output_channel_clock(output_channel_clock),
      .settle_speed_select(settle_speed_select),
      .in_sample(in_sample), .in_valid(in_valid), .in_ready(in_ready),
      .out_sample(out_sample), .out_valid(out_valid), .mute(mute),
      .coef(coef));
   asrc_audio_partner u_src (.sys_clk(sys_clk), .in_per(in_per),
      .out_per(out_per), .in_run(in_run), .out_run(out_run),
      .src_en(src_en), .input_channel_clock(input_channel_clock),
      .output_channel_clock(output_channel_clock),
      .in_sample(in_sample), .in_valid(in_valid), .in_ready(in_ready));

   initial
   begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %0t %s: %h vs %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         errors++;
         $display("[FAIL] %0t run timed out", $time);
         print_verdict();
      end
   end

   // ********
   // reference model: source words queue up, each input lr edge takes one
   // ********
   task automatic frame_check;
      d = ring_last - int'(out_sample.left);
      tgt = int'(CUT_NUM) / int'(up ? in_per : out_per) + int'(CUT_HYST_HZ);
      if (!mute)
         check(32'(d >= 2 && d <= 7), 32'h1, "spacing");
      check(32'(coef.cutoff <= tgt), 32'h1, "cutoff");
      check(32'(coef.taps - et + 2 <= 4), 32'h1, "taps");
      check(32'(coef.step - es + 64 <= 128), 32'h1, "step");
   endtask : frame_check

   always @(posedge sys_clk)
   begin
      if (!arst_n)
         acc_q.delete();
      else
      begin
         if (in_valid && in_ready)
            acc_q.push_back(int'(in_sample.left));
         if (input_channel_clock && !lr_q && acc_q.size() > 0)
            ring_last = acc_q.pop_front();
         if (out_valid && chk_en)
            frame_check();
      end
      lr_q = input_channel_clock;
   end

   task automatic do_reset;
      chk_en = 1'b0;
      arst_n = 1'b0;
      repeat (12) @(negedge sys_clk);
      check(32'(coef.taps), 32'(TAPS_UP), "reset taps");
      arst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
   endtask : do_reset

   // taps climb linearly from 64 at unity to 128 at half rate
   task automatic set_rates(input logic [15:0] i, input logic [15:0] o);
      in_per = i;
      out_per = o;
      up = o < i;
      et = up ? 64 : 64 + (int'(o - i) * 128 / int'(o)) / 2 * 2;
      es = up ? 65536 : int'(i) * 65536 / int'(o);
   endtask : set_rates

   task automatic frames(input int n);
      repeat (n) @(posedge sys_clk iff out_valid);
      @(negedge sys_clk);
   endtask : frames

   task automatic wait_mute(input logic v, input int n);
      for (int k = 0; k < n && mute !== v; k++)
         @(posedge sys_clk iff out_valid);
      @(negedge sys_clk);
   endtask : wait_mute

   initial
   begin
      void'($urandom(32'he69a6ec9));
      @(negedge sys_clk);
      settle_speed_select = 1'($urandom);
      do_reset();
      src_en = 1'b1;
      repeat (12) @(negedge sys_clk);
      check(32'(in_ready), 32'h0, "buffer full");
      check(acc_q.size(), 32'h4, "buffer words");
      set_rates(16'h0258, 16'h0384);
      in_run = 1'b1;
      out_run = 1'b1;
      frames(6);
      chk_en = 1'b1;
      frames(6);
      settle_speed_select = ~settle_speed_select;
      frames(6);
      // second reset so the loop seeds at the upsampling ratio
      do_reset();
      set_rates(16'h0320, 16'h0258);
      frames(6);
      chk_en = 1'b1;
      frames(8);
      chk_en = 1'b0;
      in_run = 1'b0;
      wait_mute(1'b1, 20);
      check(32'(mute), 32'h1, "underflow mute");
      in_run = 1'b1;
      wait_mute(1'b0, 20);
      check(32'(mute), 32'h0, "underflow recovery");
      out_run = 1'b0;
      repeat (9600) @(negedge sys_clk);
      out_run = 1'b1;
      wait_mute(1'b1, 3);
      check(32'(mute), 32'h1, "overflow mute");
      wait_mute(1'b0, 25);
      check(32'(mute), 32'h0, "overflow recovery");
      print_verdict();
   end
endmodule : asrc_ctrl_tb
`default_nettype wire
